// ---- hw/ssap_port.sv ----
// SPI slave port with attention output, sleep control and outbound FIFO.
// Overview of operation
// - Slave only; never drives clock or starts.
// - Mode 0: sample on rising clock edge.
// - Bytes shift most significant bit first.
// - Attention low while data queued, always driven.
// - Attention held until all queued bytes out.
// - Drive slave-out only while selected.
// - Every byte full duplex; filler bytes invalid.
// - Valid bytes may flow both ways together.
// - Only unescaped API mode; mode setting ignored.
// - Pull-ups on inputs enabled by default.
// - Sleep-request pin controls sleep by default.
// - Else select controls sleep: low wakes.
// - Neither configured: device stays awake.
module ssap_port
  import ssap_pkg::*;
#(
  parameter int unsigned DEPTH = SSAP_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // SPI pins.
  input wire logic spi_clk_i,
  input wire logic select_n_i,
  input wire logic slave_in_i,
  output logic slave_out_o,
  output logic slave_out_oe_o,
  output logic attention_n_o,
  // Sleep pin and configuration.
  input wire logic sleep_request_io_i,
  input wire ssap_cfg_t cfg_i,
  output logic pull_up_en_o,
  output logic awake_o,
  // Outbound bytes from the device.
  input wire logic tx_valid_i,
  input wire logic [SSAP_BYTE_W-1:0] tx_data_i,
  output logic tx_ready_o,
  // Inbound bytes to the device.
  output logic rx_valid_o,
  output logic [SSAP_BYTE_W-1:0] rx_data_o,
  output logic api_mode_o
);
  logic clk_s1;
  logic clk_s2;
  logic clk_d;
  logic sel_s1;
  logic sel_s2;
  logic sel_d;
  logic mosi_s1;
  logic mosi_s2;
  logic slp_s1;
  logic slp_s2;
  logic rise;
  logic fall;
  logic sel_fall;
  logic selected;
  logic [2:0] bit_idx;
  logic [SSAP_BYTE_W-1:0] rx_shift;
  logic [SSAP_BYTE_W-1:0] tx_shift;
  logic byte_done;
  logic fifo_valid;
  logic [SSAP_BYTE_W-1:0] fifo_data;
  logic fifo_pop;
  logic loaded;
  ssap_byte_t cur;
  ssap_state_t state;
  ssap_state_t next_state;

  // Two-stage synchronisers for every pin input.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_d <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_d <= 1'b1;
      mosi_s1 <= 1'b1;
      mosi_s2 <= 1'b1;
      slp_s1 <= 1'b1;
      slp_s2 <= 1'b1;
    end else begin
      clk_s1 <= spi_clk_i;
      clk_s2 <= clk_s1;
      clk_d <= clk_s2;
      sel_s1 <= select_n_i;
      sel_s2 <= sel_s1;
      sel_d <= sel_s2;
      mosi_s1 <= slave_in_i;
      mosi_s2 <= mosi_s1;
      slp_s1 <= sleep_request_io_i;
      slp_s2 <= slp_s1;
    end
  end

  assign selected = !sel_s2;
  assign rise = selected && clk_s2 && !clk_d;
  assign fall = selected && !clk_s2 && clk_d;
  assign sel_fall = !sel_s2 && sel_d;
  assign byte_done = rise && (bit_idx == SSAP_LSB_IDX);
  assign fifo_pop = byte_done && cur.valid;

  ssap_fifo #(
    .WIDTH(SSAP_BYTE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_valid_i(tx_valid_i),
    .wr_data_i(tx_data_i),
    .wr_ready_o(tx_ready_o),
    .rd_valid_o(fifo_valid),
    .rd_data_o(fifo_data),
    .rd_ready_i(fifo_pop)
  );

  // Byte framing state.
  always_comb begin
    next_state = state;
    case (state)
      SSAP_IDLE: begin
        if (sel_fall) begin
          next_state = SSAP_SHIFT;
        end
      end
      SSAP_SHIFT: begin
        if (!selected) begin
          next_state = SSAP_IDLE;
        end else if (byte_done) begin
          next_state = SSAP_DONE;
        end
      end
      SSAP_DONE: begin
        next_state = selected ? SSAP_SHIFT : SSAP_IDLE;
      end
      default: begin
        next_state = SSAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SSAP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter runs from bit 7 down to bit 0.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_idx <= SSAP_MSB_IDX;
    end else if (!selected) begin
      bit_idx <= SSAP_MSB_IDX;
    end else if (rise) begin
      bit_idx <= bit_idx - 3'h1;
    end
  end

  // Receive shifter samples on the rising edge.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_shift <= '0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end else begin
      rx_valid_o <= 1'b0;
      if (rise) begin
        rx_shift <= {rx_shift[SSAP_BYTE_W-2:0], mosi_s2};
      end
      if (byte_done) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= {rx_shift[SSAP_BYTE_W-2:0], mosi_s2};
      end
    end
  end

  // Transmit byte is a queued byte or filler when nothing is queued.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
      loaded <= 1'b0;
    end else if (!selected || byte_done) begin
      loaded <= 1'b0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      cur.valid <= fifo_valid;
      cur.data <= fifo_valid ? fifo_data : SSAP_FILLER;
    end
  end

  // Output shifter presents the first bit when the byte loads and each later bit after the falling edge.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_shift <= SSAP_FILLER;
      slave_out_o <= 1'b1;
      slave_out_oe_o <= 1'b0;
    end else begin
      slave_out_oe_o <= selected;
      if (selected && !loaded) begin
        tx_shift <= fifo_valid ? fifo_data : SSAP_FILLER;
        slave_out_o <= fifo_valid ? fifo_data[SSAP_MSB_IDX]
                                  : SSAP_FILLER[SSAP_MSB_IDX];
      end else if (fall && bit_idx != SSAP_MSB_IDX) begin
        slave_out_o <= tx_shift[bit_idx];
      end
    end
  end

  // Attention is low while any byte remains queued or in flight.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      attention_n_o <= 1'b1;
    end else begin
      attention_n_o <= !(fifo_valid || (loaded && cur.valid
                                        && !byte_done));
    end
  end

  // Configuration and sleep control.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pull_up_en_o <= 1'b1;
      awake_o <= 1'b1;
      api_mode_o <= 1'b1;
    end else begin
      pull_up_en_o <= cfg_i.pull_resistor_enable;
      api_mode_o <= 1'b1;
      if (cfg_i.sleep_request_periph) begin
        awake_o <= !slp_s2;
      end else if (cfg_i.select_periph) begin
        awake_o <= selected;
      end else begin
        awake_o <= 1'b1;
      end
    end
  end

  attn_queue_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fifo_valid |=> !attention_n_o)
    else $error("Attention not low while data queued.");

  attn_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!fifo_valid && !loaded) |=> attention_n_o)
    else $error("Attention low with nothing queued.");

  miso_oe_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sel_s2 |=> !slave_out_oe_o)
    else $error("Slave-out driven while deselected.");

  bit_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rise && selected && bit_idx == SSAP_MSB_IDX) |=>
      (bit_idx == 3'h6))
    else $error("Bit order counter wrong.");

  rx_byte_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    byte_done |=> rx_valid_o ##1 !rx_valid_o)
    else $error("Received byte strobe wrong.");

  sleep_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!cfg_i.sleep_request_periph && cfg_i.select_periph && sel_s2)
      |=> !awake_o)
    else $error("Select high did not sleep.");

  stay_awake_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!cfg_i.sleep_request_periph && !cfg_i.select_periph)
      |=> awake_o)
    else $error("Device slept with no sleep pin.");

  sleep_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg_i.sleep_request_periph |=> (awake_o == !$past(slp_s2)))
    else $error("Sleep pin not followed.");

  api_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ##1 api_mode_o)
    else $error("API mode left.");

  pull_up_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    1'b1 |=> (pull_up_en_o == $past(cfg_i.pull_resistor_enable)))
    else $error("Pull-up enable not followed.");

  frame_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state == SSAP_DONE) |-> rx_valid_o)
    else $error("Byte end without received strobe.");

  rx_data_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    byte_done |=> (rx_data_o == $past({rx_shift[SSAP_BYTE_W-2:0], mosi_s2})))
    else $error("Received byte not assembled in order.");

  shift_in_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rise |=> (rx_shift[0] == $past(mosi_s2)))
    else $error("Input bit not taken on rising edge.");

  out_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (selected && !loaded && !fifo_valid) |=>
      (slave_out_o == SSAP_FILLER[SSAP_MSB_IDX]))
    else $error("First filler bit wrong.");

  out_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (selected && loaded && !fall) |=> $stable(slave_out_o))
    else $error("Slave-out changed off the falling edge.");

  oe_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !sel_s2 |=> slave_out_oe_o)
    else $error("Slave-out not driven while selected.");

  pop_valid_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fifo_pop |-> fifo_valid)
    else $error("Queue popped while empty.");

  filler_data_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (loaded && !cur.valid) |-> (cur.data == SSAP_FILLER))
    else $error("Invalid byte is not filler.");

  idx_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !selected |=> (bit_idx == SSAP_MSB_IDX))
    else $error("Bit counter not reset on deselect.");

  attn_flight_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (loaded && cur.valid && !byte_done) |=> !attention_n_o)
    else $error("Attention released with byte in flight.");

  full_queued_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !tx_ready_o |-> fifo_valid)
    else $error("Queue full but nothing queued.");

  sel_wake_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!cfg_i.sleep_request_periph && cfg_i.select_periph && !sel_s2)
      |=> awake_o)
    else $error("Select low did not wake.");
endmodule : ssap_port

// ---- hw/ssap_pkg.sv ----
// Package with shared constants and carrier types for the SPI attention port.
package ssap_pkg;

  localparam int unsigned SSAP_BYTE_W = 8;
  localparam int unsigned SSAP_FIFO_DEPTH = 16;
  localparam logic [2:0] SSAP_MSB_IDX = 3'h7;
  localparam logic [2:0] SSAP_LSB_IDX = 3'h0;
  localparam logic [7:0] SSAP_FILLER = 8'hFF;
  localparam logic [7:0] SSAP_API_MODE_UNESCAPED = 8'h01;
  localparam real SSAP_CLK_MHZ = 40.0;
  localparam real SSAP_MAX_LINK_MBPS = 3.5;
  localparam int unsigned SSAP_CYC_PER_LINK_BIT =
    int'($floor(SSAP_CLK_MHZ / SSAP_MAX_LINK_MBPS));

  // Configuration of the port's pins.
  typedef struct packed {
    logic sleep_request_periph;
    logic select_periph;
    logic pull_resistor_enable;
    logic [7:0] serial_mode_setting;
  } ssap_cfg_t;

  // One byte on its way through the port.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ssap_byte_t;

  typedef enum logic [1:0] {
    SSAP_IDLE = 2'b00,
    SSAP_SHIFT = 2'b01,
    SSAP_DONE = 2'b11
  } ssap_state_t;

endpackage : ssap_pkg

// ---- hw/ssap_fifo.sv ----
// Parameterised flip-flop FIFO with valid and ready on both sides.
module ssap_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Write side.
  input wire logic wr_valid_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  // Read side.
  output logic rd_valid_o,
  output logic [WIDTH-1:0] rd_data_o,
  input wire logic rd_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic do_wr;
  logic do_rd;
  logic [AW:0] next_cnt;

  assign rd_valid_o = (cnt != '0);
  assign next_cnt = cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  assign rd_data_o = mem[rp];
  assign do_wr = wr_valid_i && wr_ready_o;
  assign do_rd = rd_valid_o && rd_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (do_wr) begin
      mem[wp] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      wr_ready_o <= 1'b1;
    end else begin
      if (do_wr) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (do_rd) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= next_cnt;
      wr_ready_o <= (next_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule : ssap_fifo

// ---- testbench/ssap_spi_master.sv ----
// Mode 0 SPI master model that frames bytes towards the port.
module ssap_spi_master (
  // SPI pins.
  output logic spi_clk_o,
  output logic select_n_o,
  output logic slave_in_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 100;
  initial begin
    spi_clk_o = 1'b0;
    select_n_o = 1'b1;
    slave_in_o = 1'b1;
  end
  task automatic open_frame();
    select_n_o = 1'b0;
    #(2 * HALF);
  endtask : open_frame
  task automatic close_frame();
    #HALF;
    select_n_o = 1'b1;
    slave_in_o = 1'b1;
    #(2 * HALF);
  endtask : close_frame
  // A 200 ns period runs the link at 5 Mbps, above its 3.5 Mbps rate limit.
  task automatic xfer(input logic [7:0] mo, input int nbits,
                      output logic [7:0] mi);
    mi = 8'hFF;
    for (int i = 7; i > 7 - nbits; i--) begin
      slave_in_o = mo[i];
      #HALF;
      spi_clk_o = 1'b1;
      mi[i] = miso_i;
      #HALF;
      spi_clk_o = 1'b0;
    end
  endtask : xfer
endmodule : ssap_spi_master

// ---- testbench/tb_ssap_port.sv ----
// Self-checking testbench for the SPI attention port.
module tb_ssap_port
  import ssap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic srp; logic selp; logic pr; logic slp; logic seln; logic awake;
  } ssap_row_t;
  logic ref_clk, rst, spi_clk, select_n, slave_in, slave_out, oe, attn;
  logic sleep_pin, pull_up_en, awake, tx_valid, tx_ready, rx_valid, api_mode;
  logic miso;
  logic [7:0] tx_data, rx_data, got;
  logic [7:0] rxq [$];
  logic [7:0] q [$];
  ssap_cfg_t cfg;
  int errors = 0;
  int tests_run = 0;
  ssap_row_t rows [6] = '{6'b101011, 6'b101100, 6'b011101,
                          6'b010010, 6'b000111, 6'b111100};
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  assign miso = oe ? slave_out : 1'b1;
  always @(negedge ref_clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
  ssap_port u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .spi_clk_i(spi_clk),
    .select_n_i(select_n), .slave_in_i(slave_in), .slave_out_o(slave_out),
    .slave_out_oe_o(oe), .attention_n_o(attn),
    .sleep_request_io_i(sleep_pin), .cfg_i(cfg), .pull_up_en_o(pull_up_en),
    .awake_o(awake), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .api_mode_o(api_mode));
  ssap_spi_master u_master (.spi_clk_o(spi_clk), .select_n_o(select_n),
    .slave_in_o(slave_in), .miso_i(miso));
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic push(input logic [7:0] d [$]);
    logic rdy;
    foreach (d[i]) begin
      tx_valid = 1'b1;
      tx_data = d[i];
      do begin
        rdy = tx_ready;
        @(negedge ref_clk);
      end while (rdy !== 1'b1);
    end
    tx_valid = 1'b0;
  endtask : push
  task automatic complete_run();
    $display("Comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #500_000;
    errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    sleep_pin = 1'b0;
    cfg = '{1'b1, 1'b0, 1'b1, 8'h01};
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk("attention_n", 8'h01, {7'h00, attn});
    chk("oe", 8'h00, {7'h00, oe});
    foreach (rows[i]) begin
      cfg = '{rows[i].srp, rows[i].selp, rows[i].pr, 8'h02};
      sleep_pin = rows[i].slp;
      if (!rows[i].seln) u_master.open_frame();
      repeat (4) @(negedge ref_clk);
      chk("awake", {7'h00, rows[i].awake}, {7'h00, awake});
      chk("pull_up_en", {7'h00, rows[i].pr}, {7'h00, pull_up_en});
      chk("api_mode", 8'h01, {7'h00, api_mode});
      if (!rows[i].seln) u_master.close_frame();
    end
    cfg = '{1'b1, 1'b0, 1'b1, 8'h01};
    sleep_pin = 1'b0;
    rxq.delete();
    @(negedge ref_clk);
    push('{8'hA5, 8'h3C});
    repeat (3) @(negedge ref_clk);
    chk("attention_n", 8'h00, {7'h00, attn});
    u_master.open_frame();
    chk("oe", 8'h01, {7'h00, oe});
    u_master.xfer(8'h5A, 8, got);
    chk("miso", 8'hA5, got);
    chk("attention_n", 8'h00, {7'h00, attn});
    u_master.xfer(8'hC3, 8, got);
    chk("miso", 8'h3C, got);
    u_master.xfer(8'h81, 8, got);
    chk("filler", 8'hFF, got);
    u_master.close_frame();
    chk("attention_n", 8'h01, {7'h00, attn});
    chk("oe", 8'h00, {7'h00, oe});
    chk("rx_count", 8'h03, 8'(rxq.size()));
    chk("rx_data", 8'h5A, rxq[0]);
    chk("rx_data", 8'h81, rxq[2]);
    for (int i = 0; i < 16; i++) q.push_back(8'(i));
    @(negedge ref_clk);
    push(q);
    chk("tx_ready", 8'h00, {7'h00, tx_ready});
    tx_valid = 1'b1;
    tx_data = 8'hEE;
    repeat (3) @(negedge ref_clk);
    tx_valid = 1'b0;
    u_master.open_frame();
    for (int i = 0; i < 16; i++) begin
      u_master.xfer(8'h00, 8, got);
      chk("fifo_byte", 8'(i), got);
    end
    u_master.xfer(8'h00, 8, got);
    chk("filler", 8'hFF, got);
    u_master.close_frame();
    chk("attention_n", 8'h01, {7'h00, attn});
    @(negedge ref_clk);
    push('{8'h77});
    rxq.delete();
    u_master.open_frame();
    u_master.xfer(8'hAA, 3, got);
    u_master.close_frame();
    chk("rx_count", 8'h00, 8'(rxq.size()));
    chk("attention_n", 8'h00, {7'h00, attn});
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    chk("attention_n", 8'h01, {7'h00, attn});
    rst = 1'b0;
    @(negedge ref_clk);
    u_master.open_frame();
    u_master.xfer(8'h3C, 8, got);
    u_master.close_frame();
    chk("filler", 8'hFF, got);
    chk("rx_data", 8'h3C, rxq[0]);
    complete_run();
  end
endmodule : tb_ssap_port
